/* rtl/sysctl_top.sv */
// reset combining, reset cause, software resets, watchdog and clock select
// Functional notes
// - brown-out reset disabled until software enables
// - brown-out gives interrupt, or reset if enabled
// - brown-out reset held while condition persists
// - reset cause records brown-out
// - set then clear bit resets peripheral
// - reset bits match clock-gating bit layout
// - peripheral reset drives all its domains
// - software request resets whole system
// - watchdog interrupt first, reset second time-out
// - first time-out reloads counter from reload value
// - reset only if interrupt uncleared and enabled
// - regulator voltage field drives regulator
// - internal oscillator selected out of reset
// - pll and internal divided by four selectable
// - source codes pick main, internal, div4, 30k; with bypass zero code 0 gives pll and codes 1 to 3 give internal
// - only main oscillator feeds pll, bypass zero
// - bypass and extended code 7 pick rtc
// - cause flags sticky, power-on clears others
`include "sysctl_regs.svh"
module sysctl_top
  import sysctl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic por_event,
  input wire logic ext_reset_event,
  input wire logic brownout_event,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic system_reset,
  output logic [95:0] periph_reset,
  output logic brownout_irq,
  output logic watchdog_irq,
  output logic [5:0] regulator_voltage_setting,
  output clock_sel_t clock_select,
  output logic pll_enable
);
  sysctl_state_t r;
  sysctl_state_t next_r;
  logic bo_level;
  logic wr;
  logic rd;
  logic [1:0] src;
  logic [2:0] src2;
  logic bypass;
  clock_sel_t next_sel;
  reset_out_t rst_out;

  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign bo_level = r.bo_sync[1];
  assign src = r.run_clock_config[`FLD_OSCILLATOR_SOURCE_SELECT_HI:`FLD_OSCILLATOR_SOURCE_SELECT_LO];
  assign src2 = r.run_clock_config[`FLD_EXT_OSCILLATOR_SOURCE_SELECT_HI:`FLD_EXT_OSCILLATOR_SOURCE_SELECT_LO];
  assign bypass = r.run_clock_config[`FLD_BYPASS];

  always_comb begin
    next_sel = clk_internal;
    if (!bypass && src == `SRC_MAIN) begin
      next_sel = clk_pll;
    end else if (bypass && src2 == `SRC_EXT_RTC) begin
      next_sel = clk_ext_rtc;
    end else if (bypass) begin
      case (src)
        `SRC_MAIN: next_sel = clk_main;
        `SRC_INTERNAL: next_sel = clk_internal;
        `SRC_INTERNAL_DIV4: next_sel = clk_internal_div4;
        `SRC_SLOW_30K: next_sel = clk_slow_30k;
        default: next_sel = clk_internal;
      endcase
    end
  end

  always_comb begin
    next_r = r;
    next_r.bo_sync = {r.bo_sync[0], brownout_event};
    next_r.pslverr = 1'b0;
    next_r.sys_req = 1'b0;
    for (int i = 0; i < 3; i++) begin
      next_r.periph_pulse[i] = 32'h0000_0000;
    end
    // brown-out: interrupt when reset disabled, reset held while present
    next_r.bo_int = bo_level & ~r.brownout_reset_enable;
    // watchdog down-counter
    if (r.wd_int_en && r.wd_state != wd_fired) begin
      if (r.wd_count == 32'h0000_0000) begin
        if (r.wd_state == wd_count || !r.wd_int_flag) begin
          next_r.wd_int_flag = 1'b1;
          next_r.wd_count = r.watchdog_reload_value;
          next_r.wd_state = wd_second;
        end else if (r.wd_reset_en) begin
          next_r.wd_state = wd_fired;
          next_r.wd_reset = 1'b1;
        end else begin
          next_r.wd_count = r.watchdog_reload_value;
        end
      end else begin
        next_r.wd_count = r.wd_count - 32'h0000_0001;
      end
    end
    // register access
    next_r.prdata = 32'h0000_0000;
    if (rd) begin
      case (paddr)
        `OFS_BROWNOUT_CTRL:
          next_r.prdata[`BIT_BROWNOUT_RESET_EN] = r.brownout_reset_enable;
        `OFS_REGULATOR_CTRL: next_r.prdata[5:0] = r.regulator_voltage_setting;
        `OFS_RESET_CAUSE: next_r.prdata[4:0] = r.reset_cause;
        `OFS_RUN_CLOCK_CFG: next_r.prdata = r.run_clock_config;
        `OFS_PERIPH_RESET0: next_r.prdata = r.periph_reset[0];
        `OFS_PERIPH_RESET1: next_r.prdata = r.periph_reset[1];
        `OFS_PERIPH_RESET2: next_r.prdata = r.periph_reset[2];
        `OFS_SYS_RESET_REQ: next_r.prdata = 32'h0000_0000;
        `OFS_WDOG_RELOAD: next_r.prdata = r.watchdog_reload_value;
        `OFS_WDOG_VALUE: next_r.prdata = r.wd_count;
        `OFS_WDOG_CTRL: next_r.prdata[1:0] = {r.wd_reset_en, r.wd_int_en};
        `OFS_WDOG_STATUS: next_r.prdata[0] = r.wd_int_flag;
        `OFS_WDOG_INT_CLEAR: next_r.prdata = 32'h0000_0000;
        default: next_r.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      case (paddr)
        `OFS_BROWNOUT_CTRL:
          next_r.brownout_reset_enable = pwdata[`BIT_BROWNOUT_RESET_EN];
        `OFS_REGULATOR_CTRL: next_r.regulator_voltage_setting = pwdata[5:0];
        `OFS_RESET_CAUSE: next_r.reset_cause = r.reset_cause & pwdata[4:0];
        `OFS_RUN_CLOCK_CFG: next_r.run_clock_config = pwdata;
        `OFS_PERIPH_RESET0, `OFS_PERIPH_RESET1, `OFS_PERIPH_RESET2: begin
          for (int i = 0; i < 3; i++) begin
            if (paddr == (`OFS_PERIPH_RESET0 + 12'(4 * i))) begin
              // falling bit after set gives one reset pulse
              next_r.periph_pulse[i] = r.periph_reset[i] & ~pwdata;
              next_r.periph_reset[i] = pwdata;
            end
          end
        end
        `OFS_SYS_RESET_REQ: next_r.sys_req = pwdata[`BIT_SYS_RESET_REQ];
        `OFS_WDOG_RELOAD: begin
          next_r.watchdog_reload_value = pwdata;
          next_r.wd_count = pwdata;
        end
        `OFS_WDOG_CTRL: begin
          next_r.wd_int_en = r.wd_int_en | pwdata[`BIT_WDOG_INT_EN];
          next_r.wd_reset_en = pwdata[`BIT_WDOG_RESET_EN];
        end
        `OFS_WDOG_INT_CLEAR: begin
          if (!(r.wd_count == 32'h0000_0000 && r.wd_state == wd_count)) begin
            next_r.wd_int_flag = 1'b0;
            next_r.wd_state = wd_count;
          end
          next_r.wd_count = r.watchdog_reload_value;
        end
        default: next_r.pslverr = 1'b1;
      endcase
    end
    // causes recorded after the write so a cause in the same cycle wins
    if (bo_level && r.brownout_reset_enable) begin
      next_r.reset_cause[`CAUSE_BROWNOUT] = 1'b1;
    end
    if (r.wd_reset) begin
      next_r.reset_cause[`CAUSE_WDOG] = 1'b1;
    end
    if (r.sys_req) begin
      next_r.reset_cause[`CAUSE_SW] = 1'b1;
    end
    if (ext_reset_event) begin
      next_r.reset_cause[`CAUSE_EXT] = 1'b1;
    end
    // system reset clears watchdog state, clock config and peripheral resets; watchdog reset enable, brown-out enable and cause kept
    if (r.wd_reset || r.sys_req || ext_reset_event ||
        (bo_level && r.brownout_reset_enable)) begin
      next_r.wd_state = wd_count;
      next_r.wd_reset = 1'b0;
      next_r.wd_int_en = 1'b0;
      next_r.wd_int_flag = 1'b0;
      next_r.wd_count = `RST_WDOG_RELOAD;
      next_r.watchdog_reload_value = `RST_WDOG_RELOAD;
      next_r.run_clock_config = `RST_RUN_CLOCK_CFG;
      next_r.periph_reset = '0;
    end
    if (por_event) begin
      next_r.reset_cause = 5'(1 << `CAUSE_POR);
      next_r.brownout_reset_enable = 1'b0;
      next_r.regulator_voltage_setting = 6'(`RST_REGULATOR);
      next_r.run_clock_config = `RST_RUN_CLOCK_CFG;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.reset_cause <= 5'(1 << `CAUSE_POR);
      r.run_clock_config <= `RST_RUN_CLOCK_CFG;
      r.watchdog_reload_value <= `RST_WDOG_RELOAD;
      r.wd_count <= `RST_WDOG_RELOAD;
      r.wd_state <= wd_count;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  // one reset strobe per peripheral covers every clock domain of that unit
  for (genvar g = 0; g < 96; g++) begin : g_periph
    assign rst_out.periph[g] = r.periph_pulse[g / 32][g % 32] | rst_out.system;
  end
  assign rst_out.system = r.wd_reset | r.sys_req | ext_reset_event |
    por_event | (bo_level & r.brownout_reset_enable);

  assign system_reset = rst_out.system;
  assign periph_reset = rst_out.periph;
  assign brownout_irq = r.bo_int;
  assign watchdog_irq = r.wd_int_flag;
  assign regulator_voltage_setting = r.regulator_voltage_setting;
  assign clock_select = next_sel;
  assign pll_enable = (next_sel == clk_pll);
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
endmodule

/* rtl/sysctl_regs.svh */
// register offsets, field positions, reset values and codes of the system control block
`ifndef SYSCTL_REGS_SVH
`define SYSCTL_REGS_SVH
`define OFS_BROWNOUT_CTRL 12'h030
`define OFS_REGULATOR_CTRL 12'h034
`define OFS_RESET_CAUSE 12'h05C
`define OFS_RUN_CLOCK_CFG 12'h060
`define OFS_PERIPH_RESET0 12'h040
`define OFS_PERIPH_RESET1 12'h044
`define OFS_PERIPH_RESET2 12'h048
`define OFS_SYS_RESET_REQ 12'h050
`define OFS_WDOG_RELOAD 12'h100
`define OFS_WDOG_CTRL 12'h108
`define OFS_WDOG_INT_CLEAR 12'h10C
`define OFS_WDOG_STATUS 12'h110
`define OFS_WDOG_VALUE 12'h104
`define BIT_BROWNOUT_RESET_EN 1
`define BIT_SYS_RESET_REQ 2
`define BIT_WDOG_INT_EN 0
`define BIT_WDOG_RESET_EN 1
`define CAUSE_EXT 0
`define CAUSE_POR 1
`define CAUSE_BROWNOUT 2
`define CAUSE_WDOG 3
`define CAUSE_SW 4
`define RST_RUN_CLOCK_CFG 32'h0000_0010
`define RST_REGULATOR 32'h0000_0000
`define RST_WDOG_RELOAD 32'hFFFF_FFFF
`define FLD_OSCILLATOR_SOURCE_SELECT_LO 4
`define FLD_OSCILLATOR_SOURCE_SELECT_HI 5
`define FLD_BYPASS 11
`define FLD_EXT_OSCILLATOR_SOURCE_SELECT_LO 12
`define FLD_EXT_OSCILLATOR_SOURCE_SELECT_HI 14
`define SRC_MAIN 2'h0
`define SRC_INTERNAL 2'h1
`define SRC_INTERNAL_DIV4 2'h2
`define SRC_SLOW_30K 2'h3
`define SRC_EXT_RTC 3'h7
`define REG_VOLT_W 6
`endif

/* rtl/sysctl_pkg.sv */
// types of the system control block
package sysctl_pkg;
  typedef enum logic [2:0] {
    clk_internal = 3'b000,
    clk_internal_div4 = 3'b001,
    clk_main = 3'b010,
    clk_slow_30k = 3'b011,
    clk_ext_rtc = 3'b100,
    clk_pll = 3'b101
  } clock_sel_t;
  typedef enum logic [1:0] {
    wd_count = 2'b00,
    wd_second = 2'b01,
    wd_fired = 2'b10
  } wdog_state_t;
  typedef struct packed {
    logic [1:0] bo_sync;
    logic brownout_reset_enable;
    logic [4:0] reset_cause;
    logic por_seen;
    logic [2:0][31:0] periph_reset;
    logic [2:0][31:0] periph_pulse;
    logic sys_req;
    logic [5:0] regulator_voltage_setting;
    logic [31:0] run_clock_config;
    logic [31:0] watchdog_reload_value;
    logic [31:0] wd_count;
    logic wd_int_en;
    logic wd_reset_en;
    logic wd_int_flag;
    wdog_state_t wd_state;
    logic wd_reset;
    logic bo_int;
    logic [31:0] prdata;
    logic pslverr;
  } sysctl_state_t;
  typedef struct packed {
    logic [95:0] periph;
    logic system;
  } reset_out_t;
endpackage

/* testbench/sysctl_checker.sv */
// port assertions for the system control block
`include "sysctl_regs.svh"
module sysctl_checker
  import sysctl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic por_event,
  input wire logic ext_reset_event,
  input wire logic brownout_event,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic system_reset,
  input wire logic [95:0] periph_reset,
  input wire logic brownout_irq,
  input wire logic [5:0] regulator_voltage_setting,
  input wire clock_sel_t clock_select,
  input wire logic pll_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr(logic [11:0] a);
    psel && penable && pwrite && clk_en && paddr == a;
  endsequence
  chk_sys_request: assert property (
    s_wr(`OFS_SYS_RESET_REQ) ##0 pwdata[`BIT_SYS_RESET_REQ] |=> system_reset)
    else $error("system reset request lost");
  chk_reg_volt: assert property (
    s_wr(`OFS_REGULATOR_CTRL) |=>
    {26'h0, regulator_voltage_setting} == ($past(pwdata) & 32'h0000_003f))
    else $error("regulator setting wrong");
  chk_unmapped_err: assert property (psel && penable && paddr == 12'h200 |=> pslverr)
    else $error("no slave error");
  chk_hard_reset: assert property (
    por_event || ext_reset_event |-> system_reset)
    else $error("pin reset not passed on");
  chk_all_periph: assert property (system_reset |-> &periph_reset)
    else $error("peripheral missed system reset");
  chk_periph_pulse: assert property (
    periph_reset != 96'h0 && !system_reset |=> periph_reset == 96'h0 || system_reset)
    else $error("peripheral reset too long");
  chk_bo_sync: assert property (
    brownout_event [*4] |-> brownout_irq || system_reset)
    else $error("brown-out not acted on");
  chk_bo_quiet: assert property (!brownout_event [*4] |-> !brownout_irq)
    else $error("brown-out irq without cause");
  chk_pll_main: assert property (pll_enable |-> clock_select == clk_pll)
    else $error("pll enabled off main path");
  chk_clock_por: assert property ($rose(presetn) |-> clock_select == clk_internal)
    else $error("clock not internal after reset");
endmodule
bind sysctl_top sysctl_checker chk_i (.pclk, .presetn, .clk_en, .por_event, .ext_reset_event,
  .brownout_event, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .system_reset,
  .periph_reset, .brownout_irq, .regulator_voltage_setting, .clock_select, .pll_enable);

/* testbench/periph_model.sv */
// core and peripheral sink that records every reset line seen
module periph_model (
  input wire logic pclk,
  input wire logic clr,
  input wire logic system_reset,
  input wire logic [95:0] periph_reset,
  output logic [95:0] seen
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge pclk) begin
    if (clr) begin
      seen <= 96'h0;
    end else begin
      seen <= seen | periph_reset | {96{system_reset}};
    end
  end
endmodule

/* testbench/tb.sv */
// testbench for the system control block
module tb;
  import sysctl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, por_event = 0, ext_reset_event = 0, brownout_event = 0;
  logic psel = 0, penable = 0, pwrite = 0, clr = 1, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, system_reset, brownout_irq, watchdog_irq, pll_enable;
  logic [95:0] periph_reset, seen;
  logic [5:0] regulator_voltage_setting;
  clock_sel_t clock_select;
  int n_errors = 0, n_tests = 0, cyc = 0;
  // main oscillator taken as stable and in pll range
  logic [31:0] cfg [6] = '{32'h0000_0800, 32'h0000_0810, 32'h0000_0820, 32'h0000_0830,
    32'h0000_7800, 32'h0000_0000};
  clock_sel_t sel [6] = '{clk_main, clk_internal, clk_internal_div4, clk_slow_30k,
    clk_ext_rtc, clk_pll};
  sysctl_top uut (.pclk, .presetn, .clk_en(1'b1), .por_event, .ext_reset_event,
    .brownout_event, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .system_reset, .periph_reset, .brownout_irq, .watchdog_irq, .regulator_voltage_setting,
    .clock_select, .pll_enable);
  periph_model peer (.pclk, .clr, .system_reset, .periph_reset, .seen);
  always #5 pclk = ~pclk;
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
    rd = prdata;
    err = pslverr;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic wt(ref logic s);
    logic v;
    v = 1'b0;
    for (int i = 0; i < 300 && !v; i++) begin
      @(posedge pclk);
      #1 v = (s === 1'b1);
    end
    chk(v, 1'b1);
  endtask
  task automatic clear();
    @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    clr <= 1'b0;
    rdc(12'h05c, 32'h0000_0002);
    rdc(12'h060, 32'h0000_0010);
    chk(clock_select, clk_internal);
    for (int i = 0; i < 6; i++) begin
      acc(1'b1, 12'h060, cfg[i]);
      chk(clock_select, sel[i]);
      chk(pll_enable, i == 5);
    end
    $display("clock select done");
    acc(1'b1, 12'h034, 32'h0000_002a);
    chk(regulator_voltage_setting, 6'h2a);
    rdc(12'h034, 32'h0000_002a);
    @(posedge pclk);
    brownout_event <= 1'b1;
    repeat (4) @(posedge pclk);
    #1 chk(brownout_irq, 1'b1);
    chk(system_reset, 1'b0);
    acc(1'b1, 12'h030, 32'h0000_0002);
    repeat (5) @(posedge pclk);
    #1 chk(system_reset, 1'b1);
    @(posedge pclk);
    brownout_event <= 1'b0;
    repeat (4) @(posedge pclk);
    #1 chk(system_reset, 1'b0);
    rdc(12'h05c, 32'h0000_0006);
    $display("brown-out done");
    clear();
    acc(1'b1, 12'h044, 32'h0000_0008);
    acc(1'b1, 12'h044, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    #1 chk(seen, 96'h1 << 35);
    clear();
    acc(1'b1, 12'h050, 32'h0000_0004);
    repeat (2) @(posedge pclk);
    #1 chk(seen, {96{1'b1}});
    rdc(12'h05c, 32'h0000_0016);
    $display("software resets done");
    acc(1'b1, 12'h100, 32'h0000_0014);
    acc(1'b1, 12'h108, 32'h0000_0003);
    wt(watchdog_irq);
    acc(1'b1, 12'h10c, 32'h0000_0000);
    @(posedge pclk);
    #1 chk(watchdog_irq, 1'b0);
    wt(system_reset);
    rdc(12'h05c, 32'h0000_001e);
    $display("watchdog done");
    acc(1'b0, 12'h200, 32'h0000_0000);
    chk(err, 1'b1);
    @(posedge pclk);
    ext_reset_event <= 1'b1;
    @(posedge pclk);
    ext_reset_event <= 1'b0;
    rdc(12'h05c, 32'h0000_001f);
    @(posedge pclk);
    por_event <= 1'b1;
    @(posedge pclk);
    por_event <= 1'b0;
    rdc(12'h05c, 32'h0000_0002);
    $display("reset causes done");
    summarize();
  end
endmodule
